// file: logic/psr_regbank.sv
/*
 * Holds the byte-wide register bank with its auto-increment pointer.
 * Assumes a serial front end that delivers address and data bytes as
 * one-cycle strobes, and a measurement core that feeds sample values.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Address 00h shows sample status if queue off, queue status if on.
// - Live 20-bit pressure split over 01h, 02h and upper nibble of 03h.
// - Live 12-bit temperature at 04h and 05h, read-only, reset zero.
// - Burst reads step from 05h back to 00h.
// - Sample status at 06h, pointer steps on to 07h.
// - 20-bit pressure change at 07h through 09h.
// - 12-bit temperature change at 0Ah, 0Bh; pointer wraps 0Bh to 06h.
// - 0Ch returns fixed identity code, untouched by mode changes.
// - Queue status at 0Dh, read-only, resets to zero.
// - Queue data port 0Eh; pointer stays there during bursts.
// - With queue on, 01h aliases the queue data port.
// - Queue setup at 0Fh, writable, reset zero, kept on mode change.
// - Elapsed time at 10h read-only, cleared on standby to active.
// - Operating state at 11h read-only, cleared on standby to active.
// - Interrupt cause at 12h read-only, not cleared on mode change.
// - Data event setup at 13h writable, reset zero.
// - Sea level reference 14h/15h resets to C5h and E7h.
// - Pressure goal 16h/17h writable, reset zero.
// - Temperature goal 18h writable, reset zero.
// - Pressure band 19h/1Ah writable, reset zero.
// - Temperature band 1Bh writable, reset zero.
// - Lowest pressure top byte at 1Ch writable, kept on mode change.
// - Queue mode field: 00 off, 01 circular, 10 full stop.
// - Sea level reference counts two pascals per step.
// - Marked registers clear on standby to active, kept otherwise.
module psr_regbank #(
    parameter logic [7:0] PART_CODE = 8'h5A // Arbitrary identity value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic addr_load,
    input wire logic [7:0] addr_byte,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    output logic [7:0] reg_ptr,
    input wire logic active_mode,
    input wire logic sample_stb,
    input wire logic [19:0] pres_in,
    input wire logic [11:0] temp_in,
    input wire logic [19:0] pres_delta_in,
    input wire logic [11:0] temp_delta_in,
    input wire logic [7:0] sample_status_in,
    input wire logic [7:0] queue_status_in,
    input wire logic [7:0] queue_byte_in,
    input wire logic [7:0] elapsed_in,
    input wire logic [7:0] opstate_in,
    input wire logic [7:0] irq_cause_in,
    output logic queue_pop,
    output logic [1:0] queue_mode,
    output logic [7:0] queue_cfg,
    output logic [7:0] event_cfg,
    output logic [16:0] sea_level_pa,
    output logic [15:0] pres_goal,
    output logic [7:0] temp_goal,
    output logic [15:0] pres_band,
    output logic [7:0] temp_band
);
    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic [19:0] pres_r, pdel_r;
    logic [11:0] temp_r, tdel_r;
    logic [7:0] new_r, qstat_r, elapsed_r, opstate_r, irq_r;
    logic [7:0] qcfg_r, evcfg_r, sea_hi_r, sea_lo_r, pg_hi_r, pg_lo_r;
    logic [7:0] tg_r, pb_hi_r, pb_lo_r, tb_r, pmin_r;
    logic active_d_r;
    logic to_active;
    logic queue_on;
    logic [7:0] acc_addr;
    logic acc;
    logic wr_go;

    assign queue_on = (qcfg_r[psr_pkg::QMODE_LSB +: 2] != psr_pkg::QMODE_OFF);
    assign to_active = active_mode & ~active_d_r;
    assign acc = rd_stb | wr_stb;
    assign acc_addr = ptr_r;
    assign wr_go = clk_en & wr_stb;

    // Standby to active edge detector
    // Resets low so a part held in standby sees no false clear;
    // the clear lasts one enabled cycle, mirrors refill after it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_d_r <= 1'b0;
        end else if (clk_en) begin
            active_d_r <= active_mode;
        end
    end

    // ****************************************
    // Pointer successor
    // ****************************************
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic q_on);
        logic [7:0] n;
        n = a + 8'h01;
        if (a == psr_pkg::A_T_LO) begin
            n = psr_pkg::A_STATUS;
        end else if (a == psr_pkg::A_NEW) begin
            n = psr_pkg::A_DP_HI;
        end else if (a == psr_pkg::A_DT_LO) begin
            n = psr_pkg::A_NEW;
        end else if (a == psr_pkg::A_QPORT) begin
            n = psr_pkg::A_QPORT;
        end else if (a == psr_pkg::A_P_HI && q_on) begin
            n = psr_pkg::A_P_HI;
        end
        return n;
    endfunction : next_addr

    // Pointer load and advance
    always_comb begin
        ptr_nxt = ptr_r;
        if (addr_load) begin
            ptr_nxt = addr_byte;
        end else if (acc) begin
            ptr_nxt = next_addr(ptr_r, queue_on);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= psr_pkg::RST_ZERO;
        end else if (clk_en) begin
            ptr_r <= ptr_nxt;
        end
    end

    // ****************************************
    // Sample-fed read-only registers
    // ****************************************
    // Live and delta values, cleared on entering active
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pres_r <= '0;
            temp_r <= '0;
            pdel_r <= '0;
            tdel_r <= '0;
        end else if (clk_en) begin
            if (to_active) begin
                pres_r <= '0;
                temp_r <= '0;
                pdel_r <= '0;
                tdel_r <= '0;
            end else if (sample_stb) begin
                pres_r <= pres_in;
                temp_r <= temp_in;
                pdel_r <= pres_delta_in;
                tdel_r <= temp_delta_in;
            end
        end
    end

    // Status mirrors, cleared on entering active
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            new_r <= psr_pkg::RST_ZERO;
            qstat_r <= psr_pkg::RST_ZERO;
            elapsed_r <= psr_pkg::RST_ZERO;
            opstate_r <= psr_pkg::RST_ZERO;
        end else if (clk_en) begin
            if (to_active) begin
                new_r <= psr_pkg::RST_ZERO;
                qstat_r <= psr_pkg::RST_ZERO;
                elapsed_r <= psr_pkg::RST_ZERO;
                opstate_r <= psr_pkg::RST_ZERO;
            end else begin
                new_r <= sample_status_in;
                qstat_r <= queue_status_in;
                elapsed_r <= elapsed_in;
                opstate_r <= opstate_in;
            end
        end
    end

    // Interrupt cause is kept across mode changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= psr_pkg::RST_ZERO;
        end else if (clk_en) begin
            irq_r <= irq_cause_in;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    // Each register takes only its own address; others drop the write
    // Setup is not locked in active mode, the host keeps that discipline

    // Queue setup, kept across mode changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qcfg_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_QCFG) begin
            qcfg_r <= wr_data;
        end
    end

    // Data event setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evcfg_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_EVCFG) begin
            evcfg_r <= wr_data;
        end
    end

    // Sea level reference, high byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sea_hi_r <= psr_pkg::RST_SEA_HI;
        end else if (wr_go && acc_addr == psr_pkg::A_SEA_HI) begin
            sea_hi_r <= wr_data;
        end
    end

    // Sea level reference, low byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sea_lo_r <= psr_pkg::RST_SEA_LO;
        end else if (wr_go && acc_addr == psr_pkg::A_SEA_LO) begin
            sea_lo_r <= wr_data;
        end
    end

    // Pressure goal, high byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_hi_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_PG_HI) begin
            pg_hi_r <= wr_data;
        end
    end

    // Pressure goal, low byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_lo_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_PG_LO) begin
            pg_lo_r <= wr_data;
        end
    end

    // Temperature goal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tg_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_TG) begin
            tg_r <= wr_data;
        end
    end

    // Pressure band, high byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pb_hi_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_PB_HI) begin
            pb_hi_r <= wr_data;
        end
    end

    // Pressure band, low byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pb_lo_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_PB_LO) begin
            pb_lo_r <= wr_data;
        end
    end

    // Temperature band
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_TB) begin
            tb_r <= wr_data;
        end
    end

    // Lowest pressure top byte, plain store kept across mode changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pmin_r <= psr_pkg::RST_ZERO;
        end else if (wr_go && acc_addr == psr_pkg::A_PMIN_HI) begin
            pmin_r <= wr_data;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Read multiplexer with queue aliasing
    // Byte is registered so the serial side sees it steady a cycle later
    always_comb begin
        rd_nxt = rd_r;
        if (rd_stb) begin
            unique case (acc_addr)
                psr_pkg::A_STATUS: rd_nxt = queue_on ? qstat_r : new_r;
                psr_pkg::A_P_HI: rd_nxt = queue_on ? queue_byte_in : pres_r[19:12];
                psr_pkg::A_P_MID: rd_nxt = pres_r[11:4];
                psr_pkg::A_P_LO: rd_nxt = {pres_r[3:0], 4'h0};
                psr_pkg::A_T_HI: rd_nxt = temp_r[11:4];
                psr_pkg::A_T_LO: rd_nxt = {temp_r[3:0], 4'h0};
                psr_pkg::A_NEW: rd_nxt = new_r;
                psr_pkg::A_DP_HI: rd_nxt = pdel_r[19:12];
                psr_pkg::A_DP_MID: rd_nxt = pdel_r[11:4];
                psr_pkg::A_DP_LO: rd_nxt = {pdel_r[3:0], 4'h0};
                psr_pkg::A_DT_HI: rd_nxt = tdel_r[11:4];
                psr_pkg::A_DT_LO: rd_nxt = {tdel_r[3:0], 4'h0};
                psr_pkg::A_ID: rd_nxt = PART_CODE;
                psr_pkg::A_QSTAT: rd_nxt = qstat_r;
                psr_pkg::A_QPORT: rd_nxt = queue_byte_in;
                psr_pkg::A_QCFG: rd_nxt = qcfg_r;
                psr_pkg::A_ELAPSED: rd_nxt = elapsed_r;
                psr_pkg::A_OPSTATE: rd_nxt = opstate_r;
                psr_pkg::A_IRQ: rd_nxt = irq_r;
                psr_pkg::A_EVCFG: rd_nxt = evcfg_r;
                psr_pkg::A_SEA_HI: rd_nxt = sea_hi_r;
                psr_pkg::A_SEA_LO: rd_nxt = sea_lo_r;
                psr_pkg::A_PG_HI: rd_nxt = pg_hi_r;
                psr_pkg::A_PG_LO: rd_nxt = pg_lo_r;
                psr_pkg::A_TG: rd_nxt = tg_r;
                psr_pkg::A_PB_HI: rd_nxt = pb_hi_r;
                psr_pkg::A_PB_LO: rd_nxt = pb_lo_r;
                psr_pkg::A_TB: rd_nxt = tb_r;
                psr_pkg::A_PMIN_HI: rd_nxt = pmin_r;
                default: rd_nxt = psr_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= psr_pkg::RST_ZERO;
        end else if (clk_en) begin
            rd_r <= rd_nxt;
        end
    end

    // Queue drain pulse on data port or its alias
    assign queue_pop = clk_en & rd_stb & ((acc_addr == psr_pkg::A_QPORT) |
                       (queue_on & (acc_addr == psr_pkg::A_P_HI)));

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data = rd_r;
    assign reg_ptr = ptr_r;
    assign queue_cfg = qcfg_r;
    assign queue_mode = qcfg_r[psr_pkg::QMODE_LSB +: 2];
    assign event_cfg = evcfg_r;
    // Reference scaled to pascals, two per step
    assign sea_level_pa = {sea_hi_r, sea_lo_r, 1'b0};
    assign pres_goal = {pg_hi_r, pg_lo_r};
    assign temp_goal = tg_r;
    assign pres_band = {pb_hi_r, pb_lo_r};
    assign temp_band = tb_r;
endmodule : psr_regbank
`default_nettype wire

// file: logic/psr_pkg.sv
/*
 * Holds the register map constants of the sensor register bank.
 * Assumes an 8-bit register pointer loaded by a serial front end.
 */
`default_nettype none
package psr_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_P_HI = 8'h01;
    localparam logic [7:0] A_P_MID = 8'h02;
    localparam logic [7:0] A_P_LO = 8'h03;
    localparam logic [7:0] A_T_HI = 8'h04;
    localparam logic [7:0] A_T_LO = 8'h05;
    localparam logic [7:0] A_NEW = 8'h06;
    localparam logic [7:0] A_DP_HI = 8'h07;
    localparam logic [7:0] A_DP_MID = 8'h08;
    localparam logic [7:0] A_DP_LO = 8'h09;
    localparam logic [7:0] A_DT_HI = 8'h0A;
    localparam logic [7:0] A_DT_LO = 8'h0B;
    localparam logic [7:0] A_ID = 8'h0C;
    localparam logic [7:0] A_QSTAT = 8'h0D;
    localparam logic [7:0] A_QPORT = 8'h0E;
    localparam logic [7:0] A_QCFG = 8'h0F;
    localparam logic [7:0] A_ELAPSED = 8'h10;
    localparam logic [7:0] A_OPSTATE = 8'h11;
    localparam logic [7:0] A_IRQ = 8'h12;
    localparam logic [7:0] A_EVCFG = 8'h13;
    localparam logic [7:0] A_SEA_HI = 8'h14;
    localparam logic [7:0] A_SEA_LO = 8'h15;
    localparam logic [7:0] A_PG_HI = 8'h16;
    localparam logic [7:0] A_PG_LO = 8'h17;
    localparam logic [7:0] A_TG = 8'h18;
    localparam logic [7:0] A_PB_HI = 8'h19;
    localparam logic [7:0] A_PB_LO = 8'h1A;
    localparam logic [7:0] A_TB = 8'h1B;
    localparam logic [7:0] A_PMIN_HI = 8'h1C;
    localparam logic [7:0] A_PMIN_NEXT = 8'h1D;
    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SEA_HI = 8'hC5;
    localparam logic [7:0] RST_SEA_LO = 8'hE7;
    localparam int QMODE_LSB = 6;
    localparam logic [1:0] QMODE_OFF = 2'h0;
    localparam logic [1:0] QMODE_CIRC = 2'h1;
    localparam logic [1:0] QMODE_STOP = 2'h2;
    localparam int SEA_PA_PER_LSB = 2;
endpackage : psr_pkg
`default_nettype wire

// file: bench/psr_regbank_asserts.sv
/* Checker for the pointer, read path and queue pop of the register bank.
   Assumes it is bound to psr_regbank and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module psr_regbank_chk #(
    parameter logic [7:0] PART_CODE = 8'h5A
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic addr_load,
    input wire logic [7:0] addr_byte,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] reg_ptr,
    input wire logic queue_pop,
    input wire logic [1:0] queue_mode,
    input wire logic [7:0] queue_cfg,
    input wire logic [7:0] event_cfg,
    input wire logic [16:0] sea_level_pa
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Read steps, pointer moves, sea level reset value and read-only write guard
    // ****************************************
    sequence s_rd(logic [7:0] a);
        rd_stb && clk_en && !addr_load && reg_ptr == a;
    endsequence
    property p_step(logic [7:0] a, logic [7:0] b);
        s_rd(a) |=> reg_ptr == b;
    endproperty
    a_id_read: assert property (s_rd(psr_pkg::A_ID) |=> rd_data == PART_CODE)
        else $error("identity read wrong");
    a_burst_wrap: assert property (s_rd(psr_pkg::A_T_HI) ##1 s_rd(psr_pkg::A_T_LO) |=> reg_ptr == 8'h00)
        else $error("pointer did not wrap to status");
    a_delta_wrap: assert property (p_step(psr_pkg::A_DT_LO, psr_pkg::A_NEW))
        else $error("pointer did not wrap to sample status");
    a_qport_hold: assert property (p_step(psr_pkg::A_QPORT, psr_pkg::A_QPORT))
        else $error("queue port pointer moved");
    a_pop_port: assert property (rd_stb && clk_en && reg_ptr == psr_pkg::A_QPORT |-> queue_pop)
        else $error("queue port read without pop");
    a_alias_hold: assert property (rd_stb && clk_en && !addr_load && reg_ptr == 8'h01 && queue_mode != 2'h0
        |-> queue_pop ##1 reg_ptr == 8'h01)
        else $error("queue alias read wrong");
    a_load_ptr: assert property (addr_load && clk_en |=> reg_ptr == $past(addr_byte))
        else $error("pointer not loaded");
    a_sea_reset: assert property ($rose(rst_n) |-> sea_level_pa == {8'hC5, 8'hE7, 1'b0})
        else $error("sea level reference reset wrong");
    a_ro_ignore: assert property (wr_stb && clk_en && !addr_load && reg_ptr < psr_pkg::A_QCFG
        |=> $stable(queue_cfg) && $stable(event_cfg) && $stable(sea_level_pa))
        else $error("read-only write changed setup");
endmodule : psr_regbank_chk
bind psr_regbank psr_regbank_chk #(.PART_CODE(PART_CODE)) chk_i (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .addr_load(addr_load), .addr_byte(addr_byte), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .reg_ptr(reg_ptr), .queue_pop(queue_pop), .queue_mode(queue_mode),
    .queue_cfg(queue_cfg), .event_cfg(event_cfg), .sea_level_pa(sea_level_pa));
`default_nettype wire

// file: bench/psr_host_model.sv
/* Host side of the register bank: address load, burst writes, burst reads.
   Assumes strobes are taken on the rising edge and read data lands a cycle later. */
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output var logic addr_load,
    output var logic [7:0] addr_byte,
    output var logic wr_stb,
    output var logic [7:0] wr_data,
    output var logic rd_stb
);
    logic [7:0] got [0:15];
    // Idle bus at time zero
    initial begin
        addr_load = 1'b0;
        addr_byte = 8'h00;
        wr_stb = 1'b0;
        wr_data = 8'h00;
        rd_stb = 1'b0;
    end
    // Address byte, then back-to-back data bytes; setup only written in standby
    task wr_burst(input logic [7:0] a, input logic [7:0] d[$]);
        @(negedge clk);
        addr_load = 1'b1;
        addr_byte = a;
        @(negedge clk);
        addr_load = 1'b0;
        foreach (d[i]) begin
            wr_stb = 1'b1;
            wr_data = d[i];
            @(negedge clk);
        end
        wr_stb = 1'b0;
        wr_data = ~wr_data;
    endtask : wr_burst
    // Address byte, then n back-to-back reads
    task rd_burst(input logic [7:0] a, input int n);
        @(negedge clk);
        addr_load = 1'b1;
        addr_byte = a;
        @(negedge clk);
        addr_load = 1'b0;
        rd_stb = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (i == n - 1) rd_stb = 1'b0;
            got[i] = rd_data;
        end
    endtask : rd_burst
endmodule : psr_host_model
`default_nettype wire

// file: bench/test_psr_regbank.sv
/* Self-checking bench for the sensor register bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module test_psr_regbank;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic active_mode = 1'b0;
    logic sample_stb = 1'b0;
    logic [19:0] pres_in = 20'h00000, pres_delta_in = 20'h00000;
    logic [11:0] temp_in = 12'h000, temp_delta_in = 12'h000;
    logic addr_load, wr_stb, rd_stb, queue_pop;
    logic [7:0] addr_byte, wr_data, rd_data, reg_ptr, queue_cfg, event_cfg, temp_goal, temp_band;
    logic [1:0] queue_mode;
    logic [16:0] sea_level_pa;
    logic [15:0] pres_goal, pres_band;
    logic [7:0] ex[$], wq[$];
    logic [7:0] sample_status_in = 8'h64, queue_byte_in = 8'h86, irq_cause_in = 8'h53;
    int pops = 0;
    int err_total = 0, num_checks = 0;
    always #50 clk = ~clk;
    // Queue drain pulses seen by the far side
    always @(posedge clk) begin
        if (queue_pop) pops++;
    end
    psr_host_model psr_host_model_i (.clk(clk), .rd_data(rd_data), .addr_load(addr_load),
        .addr_byte(addr_byte), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb));
    psr_regbank #(.PART_CODE(8'h3C)) psr_regbank_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .addr_load(addr_load), .addr_byte(addr_byte), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_data(rd_data), .reg_ptr(reg_ptr), .active_mode(active_mode), .sample_stb(sample_stb),
        .pres_in(pres_in), .temp_in(temp_in), .pres_delta_in(pres_delta_in), .temp_delta_in(temp_delta_in),
        .sample_status_in(sample_status_in), .queue_status_in(8'h75), .queue_byte_in(queue_byte_in),
        .elapsed_in(8'h31), .opstate_in(8'h42), .irq_cause_in(irq_cause_in), .queue_pop(queue_pop),
        .queue_mode(queue_mode),
        .queue_cfg(queue_cfg), .event_cfg(event_cfg), .sea_level_pa(sea_level_pa), .pres_goal(pres_goal),
        .temp_goal(temp_goal), .pres_band(pres_band), .temp_band(temp_band));
    // ****************************************
    // Compare, burst check and closing report
    // ****************************************
    task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task run(input logic [7:0] a, input string nm);
        psr_host_model_i.rd_burst(a, ex.size());
        foreach (ex[i]) chk(nm, {9'h000, ex[i]}, {9'h000, psr_host_model_i.got[i]});
        $display("Test %s done", nm);
    endtask : run
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        ex = '{8'h00, 8'h31, 8'h42, 8'h53, 8'h00, 8'hC5, 8'hE7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        run(8'h0F, "reset");
        for (int i = 0; i < 14; i++) wq.push_back(8'hA0 + 8'(i));
        psr_host_model_i.wr_burst(8'h0F, wq);
        ex = wq;
        ex[1] = 8'h31;
        ex[2] = 8'h42;
        ex[3] = 8'h53;
        run(8'h0F, "rw");
        chk("qcfg", 17'(queue_cfg), 17'h000A0);
        chk("qmode", 17'(queue_mode), 17'(psr_pkg::QMODE_STOP));
        chk("evcfg", 17'(event_cfg), 17'h000A4);
        chk("sea", sea_level_pa, 17'(16'hA5A6 * psr_pkg::SEA_PA_PER_LSB));
        chk("pgoal", 17'(pres_goal), 17'h0A7A8);
        chk("tgoal", 17'(temp_goal), 17'h000A9);
        chk("pband", 17'(pres_band), 17'h0AAAB);
        chk("tband", 17'(temp_band), 17'h000AC);
        wq = '{8'hFF};
        psr_host_model_i.wr_burst(8'h04, wq);
        psr_host_model_i.wr_burst(8'h30, wq);
        ex = '{8'h00, 8'h00};
        run(8'h04, "rowrite");
        ex = '{8'h00};
        run(8'h30, "unmapped");
        ex = '{8'h75, 8'h86, 8'h86};
        run(8'h00, "stop");
        wq = '{8'h40};
        queue_byte_in = 8'h97;
        psr_host_model_i.wr_burst(8'h0F, wq);
        ex = '{8'h75, 8'h97, 8'h97};
        run(8'h00, "circ");
        wq = '{8'h00};
        psr_host_model_i.wr_burst(8'h0F, wq);
        @(negedge clk);
        pres_in = 20'hABCDE;
        temp_in = 12'h123;
        pres_delta_in = 20'h13579;
        temp_delta_in = 12'h9F8;
        sample_stb = 1'b1;
        @(negedge clk) sample_stb = 1'b0;
        ex = '{8'h12, 8'h30, 8'h64, 8'hAB, 8'hCD, 8'hE0, 8'h12, 8'h30};
        run(8'h04, "live");
        sample_status_in = 8'h65;
        ex = '{8'h65, 8'h13, 8'h57, 8'h90, 8'h9F, 8'h80, 8'h65, 8'h13};
        run(8'h06, "delta");
        @(negedge clk) active_mode = 1'b1;
        ex = '{8'h00, 8'h00};
        run(8'h04, "modeclr");
        irq_cause_in = 8'h54;
        ex = '{8'h54, 8'hA4};
        run(8'h12, "irqkeep");
        ex = '{8'hAD};
        run(8'h1C, "minkeep");
        ex = '{8'h3C, 8'h75, 8'h97, 8'h97};
        run(8'h0C, "idqueue");
        chk("pops", 17'(pops), 17'h00006);
        @(negedge clk) active_mode = 1'b0;
        clk_en = 1'b0;
        wq = '{8'h11};
        psr_host_model_i.wr_burst(8'h18, wq);
        clk_en = 1'b1;
        ex = '{8'hA9};
        run(8'h18, "freeze");
        tally_and_finish();
    end
endmodule : test_psr_regbank
`default_nettype wire
